// >>> testbench/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model
  import synth_load_pkg::*;
(
  input  wire logic clk,
  output logic      serial_clock,
  output logic      serial_data,
  output logic      load_strobe
);
  initial begin
    serial_clock = 1'b0;
    serial_data  = 1'b0;
    load_strobe  = 1'b0;
  end
  // Link clock only inside a frame; released data line is inverted
  task automatic send(input word_t w);
    for (int i = WORD_BITS - 1; i >= 0; i--) begin
      serial_data = w[i];
      #7.5 serial_clock = 1'b1;
      #7.5 serial_clock = 1'b0;
    end
    serial_data = ~serial_data;
    @(negedge clk);
    load_strobe = 1'b1;
    repeat (8) @(negedge clk);
    load_strobe = 1'b0;
    repeat (4) @(negedge clk);
  endtask : send
endmodule : serial_host_model

// >>> testbench/synth_load_asserts.sv
`timescale 1ns/1ps
module synth_load_asserts
  import synth_load_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       load_strobe,
  input wire logic       power_enable,
  input wire logic       reference_tick,
  input wire logic       feedback_tick,
  input wire pump_ctl_t  pump_output,
  input wire pin_drive_t speedup_output,
  input wire logic       powerdown,
  input wire logic       divider_quarter,
  input wire latch_t     function_latch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Comparison cycles seen while the fourfold current is on
  logic [6:0] tick_cnt;
  always_ff @(posedge clk) begin
    if (reset || !pump_output.x4) tick_cnt <= 7'h00;
    else if (reference_tick) tick_cnt <= tick_cnt + 7'h01;
  end
  sequence boost_steady;
    function_latch[10:8] == 3'h1 && pump_output.x4;
  endsequence
  sequence pins_quiet;
    !load_strobe [*6];
  endsequence
  a_hold_floats_pump: assert property (
    $rose(function_latch[F_HOLD]) |-> ##[0:3] pump_output.hiz)
    else $error("hold bit did not float the pump");
  a_hold_no_ticks: assert property (
    function_latch[F_HOLD] [*3] |-> !reference_tick && !feedback_tick)
    else $error("divider ticked while held");
  a_enable_low_pd: assert property (
    !power_enable [*4] |-> powerdown)
    else $error("enable low without powerdown");
  a_pd_no_ticks: assert property (
    powerdown [*2] |-> !reference_tick && !feedback_tick)
    else $error("divider ticked in powerdown");
  a_timeout_length: assert property (
    $fell(pump_output.x4) && function_latch[10:8] == 3'h5 |->
    tick_cnt == TMO_BASE + 4 * function_latch[F_TMO_HI:F_TMO_LO])
    else $error("speed-up timeout length wrong");
  a_boost_holds: assert property (
    boost_steady ##1 pins_quiet |-> pump_output.x4)
    else $error("fourfold current ended without a load");
  a_quarter_mode: assert property (
    $stable(function_latch) [*3] ##0 divider_quarter |->
    function_latch[F_SPD_QTR] && function_latch[F_SPD_EN])
    else $error("quarter ratio outside quarter mode");
  a_speedup_follows: assert property (
    (!function_latch[F_SPD_EN] && $stable(function_latch)) [*3] |->
    speedup_output.oe && speedup_output.level == function_latch[F_SPD_QTR])
    else $error("speed-up pin not following its bit");
endmodule : synth_load_asserts

bind synth_serial_load_control synth_load_asserts synth_load_asserts_i (
  .clk(clk), .reset(reset), .load_strobe(load_strobe),
  .power_enable(power_enable), .reference_tick(reference_tick),
  .feedback_tick(feedback_tick), .pump_output(pump_output),
  .speedup_output(speedup_output), .powerdown(powerdown),
  .divider_quarter(divider_quarter), .function_latch(function_latch));

// >>> testbench/synth_serial_load_control_tb.sv
`timescale 1ns/1ps
module synth_serial_load_control_tb;
  import synth_load_pkg::*;
  logic       clk, reset, power_enable, prescaler_pulse;
  logic       serial_clock, serial_data, load_strobe;
  logic       reference_tick, feedback_tick, modulus_select;
  logic       powerdown, divider_quarter, lock_precision;
  pump_ctl_t  pump_output;
  pin_drive_t speedup_output;
  latch_t     function_latch;
  int         fails, num_checks, n;
  word_t      w;

  serial_host_model serial_host_model_i (.clk(clk),
    .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe));
  synth_serial_load_control synth_serial_load_control_i (.clk(clk),
    .reset(reset), .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe), .power_enable(power_enable),
    .prescaler_pulse(prescaler_pulse), .reference_tick(reference_tick),
    .feedback_tick(feedback_tick), .modulus_select(modulus_select),
    .pump_output(pump_output), .speedup_output(speedup_output),
    .powerdown(powerdown), .divider_quarter(divider_quarter),
    .lock_precision(lock_precision), .function_latch(function_latch));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Prescaler output: one rising edge every four clocks
  always begin
    repeat (2) @(negedge clk);
    prescaler_pulse <= ~prescaler_pulse;
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic gap(input logic fb, output int len);
    for (int k = 0; k < 4000 && (fb ? feedback_tick : reference_tick)
         !== 1'b1; k++) @(negedge clk);
    len = 0;
    do begin
      @(negedge clk);
      len++;
    end while (len < 4000 && (fb ? feedback_tick : reference_tick) !== 1'b1);
  endtask : gap
  function automatic word_t fw(logic [1:0] sel, logic hold, pd,
                               logic [2:0] mode, logic [3:0] tmo);
    latch_t f;
    f = LATCH_RESET;
    f[F_HOLD] = hold;
    f[F_PD_A] = pd;
    f[F_PD_B] = pd;
    f[F_SPD_TMO:F_SPD_EN] = mode;
    f[F_TMO_HI:F_TMO_LO] = tmo;
    return {f, sel};
  endfunction : fw
  function automatic word_t nw(logic req);
    return {req, 13'h0003, 5'h01, SEL_FB};
  endfunction : nw
  function automatic word_t rw(logic prec);
    return {prec, 4'h0, 14'h0014, SEL_REF};
  endfunction : rw

  task automatic t_init_timeout;
    w = fw(SEL_INIT, 1'b0, 1'b0, 3'h5, 4'h6);
    serial_host_model_i.send(w);
    chk("function_latch", w[20:2], function_latch);
    serial_host_model_i.send(rw(1'b1));
    chk("lock_precision", 1, lock_precision);
    serial_host_model_i.send(nw(1'b1));
    chk("pump_x4", 1, pump_output.x4);
    n = 0;
    for (int k = 0; k < 3000 && pump_output.x4 === 1'b1; k++) begin
      n += reference_tick;
      @(negedge clk);
    end
    chk("timeout_ticks", TMO_BASE + 4 * 6, n);
    $display("test init_timeout done");
  endtask : t_init_timeout
  task automatic t_hold;
    serial_host_model_i.send(fw(SEL_FUNC, 1'b1, 1'b1, 3'h0, 4'h0));
    chk("pump_hiz", 1, pump_output.hiz);
    serial_host_model_i.send(rw(1'b0));
    serial_host_model_i.send(nw(1'b0));
    n = 0;
    repeat (60) @(negedge clk) n += reference_tick;
    chk("held_ticks", 0, n);
    chk("powerdown", 0, powerdown);
    serial_host_model_i.send(fw(SEL_FUNC, 1'b0, 1'b0, 3'h0, 4'h0));
    gap(1'b0, n);
    chk("ref_period", 20, n);
    gap(1'b1, n);
    chk("fb_period", 3 * 4, n);
    n = 0;
    repeat (12) @(negedge clk) n += modulus_select;
    chk("swallow_cycles", 1 * 4, n);
    $display("test hold done");
  endtask : t_hold
  task automatic t_power;
    serial_host_model_i.send(fw(SEL_INIT, 1'b0, 1'b1, 3'h0, 4'h0));
    chk("powerdown", 1, powerdown);
    power_enable = 1'b0;
    w = fw(SEL_FUNC, 1'b0, 1'b0, 3'h3, 4'h0);
    serial_host_model_i.send(w);
    chk("powerdown", 1, powerdown);
    serial_host_model_i.send(rw(1'b1));
    chk("lock_precision", 1, lock_precision);
    power_enable = 1'b1;
    repeat (5) @(negedge clk);
    chk("powerdown", 0, powerdown);
    chk("function_latch", w[20:2], function_latch);
    n = 0;
    fork
      serial_host_model_i.send(nw(1'b1));
      repeat (30) @(negedge clk) n += pump_output.hiz;
    join
    chk("pulse_cycles", 1, n);
    chk("divider_quarter", 1, divider_quarter);
    gap(1'b0, n);
    chk("ref_period", 20 >> QTR_SHIFT, n);
    serial_host_model_i.send(nw(1'b0));
    chk("divider_quarter", 0, divider_quarter);
    $display("test power done");
  endtask : t_power
  task automatic t_modes;
    serial_host_model_i.send(fw(SEL_FUNC, 1'b0, 1'b0, 3'h1, 4'h0));
    n = 0;
    fork
      serial_host_model_i.send(nw(1'b1));
      repeat (30) @(negedge clk) n += pump_output.hiz;
    join
    chk("pulse_cycles", 0, n);
    chk("speedup_output", 2'h1, speedup_output);
    repeat (100) @(negedge clk);
    chk("pump_x4", 1, pump_output.x4);
    serial_host_model_i.send(nw(1'b0));
    chk("pump_x4", 0, pump_output.x4);
    chk("speedup_output", 2'h0, speedup_output);
    serial_host_model_i.send(fw(SEL_FUNC, 1'b0, 1'b0, 3'h2, 4'h0));
    serial_host_model_i.send(nw(1'b1));
    chk("speedup_output", 2'h3, speedup_output);
    chk("pump_high", 1, pump_output.high);
    $display("test modes done");
  endtask : t_modes

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    fails = 0;
    num_checks = 0;
    reset = 1'b1;
    power_enable = 1'b1;
    prescaler_pulse = 1'b0;
    repeat (6) @(negedge clk);
    reset = 1'b0;
    t_init_timeout();
    t_hold();
    t_power();
    t_modes();
    conclude();
  end
endmodule : synth_serial_load_control_tb

// >>> verilog/synth_load_pkg.sv
package synth_load_pkg;

  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 21;
  localparam int DATA_MSB  = 19;

  typedef logic [WORD_BITS-1:0] word_t;
  typedef logic [DATA_MSB:1]    latch_t;

  // Destination select, written as {first, last}
  localparam logic [1:0] SEL_REF  = 2'h0;
  localparam logic [1:0] SEL_FB   = 2'h2;
  localparam logic [1:0] SEL_FUNC = 2'h1;
  localparam logic [1:0] SEL_INIT = 2'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int F_HOLD     = 1;
  localparam int F_PD_A     = 2;
  localparam int F_PD_B     = 18;
  localparam int F_SPD_EN   = 8;
  localparam int F_SPD_QTR  = 9;
  localparam int F_SPD_TMO  = 10;
  localparam int F_TMO_LO   = 11;
  localparam int F_TMO_HI   = 14;
  localparam int N_GO       = 19;
  localparam int N_MAIN_HI  = 18;
  localparam int N_MAIN_LO  = 6;
  localparam int N_SWAL_HI  = 5;
  localparam int N_SWAL_LO  = 1;
  localparam int R_PREC     = 19;
  localparam int R_RATIO_HI = 14;
  localparam int R_RATIO_LO = 1;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam latch_t     LATCH_RESET = 19'h0_0000;
  localparam logic [5:0] TMO_BASE    = 6'h03;
  localparam int         QTR_SHIFT   = 2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hiz;
    logic x4;
    logic high;
  } pump_ctl_t;

  typedef struct packed {
    logic level;
    logic oe;
  } pin_drive_t;

endpackage : synth_load_pkg

// >>> verilog/synth_serial_load_control.sv
`timescale 1ns/1ps

// Contract
// [RULE_01] Each programming word is exactly 21 bits long.
// [RULE_02] Last two bits route: 00 ref, 10 feedback, 01 function, 11 init.
// [RULE_03] Host sends words most significant bit first, select bits last.
// [RULE_04] One data bit is shifted in per rising serial clock edge.
// [RULE_05] Rising load strobe moves the word into the selected latch.
// [RULE_06] Init word loads the function latch and fires one reset pulse.
// [RULE_07] Reset pulse reloads dividers and timeout, floats the pump.
// [RULE_08] Pulse with enable, both powerdown bits high enters powerdown.
// [RULE_09] First feedback load after init fires the pulse again, later not.
// [RULE_10] Host sends init, reference, feedback words back to back.
// [RULE_11] Loads are kept during powerdown; dividers restart aligned.
// [RULE_12] Latches survive power-enable cycling without reprogramming.
// [RULE_13] Hold bit keeps dividers at load, floats pump, no powerdown.
// [RULE_14] Host sets hold, loads dividers, then clears hold.
// [RULE_15] Feedback word: bit 19 request, 18..6 main, 5..1 swallow.
// [RULE_16] Feedback division is modulus times main plus swallow.
// [RULE_17] Host keeps main count at least 3 and not below swallow.
// [RULE_18] Reference word: bit 19 lock precision, 14..1 ratio.
// [RULE_19] Host writes zeros into reference bits 18..15.
// [RULE_20] Mode 100 with request holds fourfold current until cleared; the code does this in mode 001, and mode 100 drives pump high, not x4.
// [RULE_21] Mode 101 holds fourfold current for the timeout, then clears.
// [RULE_22] Function bits 14..11 set the timeout in comparison cycles.
// [RULE_23] Timeout is 3 plus 4 times the field, one step per cycle.
// [RULE_24] Quarter modes add a further fourfold gain during speed-up.
// [RULE_25] Quarter modes divide both ratios by four while requested.
// [RULE_26] With speed-up off, output follows bit 9, request sets 1 mA.
module synth_serial_load_control
  import synth_load_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       serial_clock,
  input  wire logic       serial_data,
  input  wire logic       load_strobe,
  input  wire logic       power_enable,
  input  wire logic       prescaler_pulse,
  output logic            reference_tick,
  output logic            feedback_tick,
  output logic            modulus_select,
  output pump_ctl_t       pump_output,
  output pin_drive_t      speedup_output,
  output logic            powerdown,
  output logic            divider_quarter,
  output logic            lock_precision,
  output latch_t          function_latch
);

  // ----------------------------------------------------------------
  // Serial shift register, link clock domain
  // ----------------------------------------------------------------
  word_t shift_reg;

  // No reset: the serial clock only runs during a frame
  always_ff @(posedge serial_clock) begin // [RULE_01] [RULE_03]
    shift_reg <= {shift_reg[WORD_BITS-2:0], serial_data}; // [RULE_04]
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic strobe_meta;
  logic strobe_sync;
  logic strobe_last;
  logic enable_meta;
  logic enable_sync;
  logic pre_meta;
  logic pre_sync;
  logic pre_last;

  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
      strobe_last <= 1'b0;
      enable_meta <= 1'b0;
      enable_sync <= 1'b0;
      pre_meta    <= 1'b0;
      pre_sync    <= 1'b0;
      pre_last    <= 1'b0;
    end else begin
      strobe_meta <= load_strobe;
      strobe_sync <= strobe_meta;
      strobe_last <= strobe_sync;
      enable_meta <= power_enable;
      enable_sync <= enable_meta;
      pre_meta    <= prescaler_pulse;
      pre_sync    <= pre_meta;
      pre_last    <= pre_sync;
    end
  end

  logic       load_now;
  logic       fb_edge;
  logic [1:0] sel;
  latch_t     word_data;

  // Shift register is static while the strobe is high
  assign load_now  = strobe_sync & ~strobe_last; // [RULE_05]
  assign fb_edge   = pre_sync & ~pre_last;
  assign sel       = shift_reg[1:0];
  assign word_data = shift_reg[WORD_BITS-1:2];

  logic load_ref;
  logic load_fb;
  logic load_func;
  logic load_init;

  assign load_ref  = load_now & (sel == SEL_REF); // [RULE_02]
  assign load_fb   = load_now & (sel == SEL_FB);
  assign load_func = load_now & (sel == SEL_FUNC);
  assign load_init = load_now & (sel == SEL_INIT);

  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  latch_t ref_latch;
  latch_t fb_latch;

  // Only the supply reset clears these; powerdown leaves them intact
  always_ff @(posedge clk) begin
    if (reset) begin
      ref_latch      <= LATCH_RESET;
      fb_latch       <= LATCH_RESET;
      function_latch <= LATCH_RESET;
    end else begin
      if (load_ref) begin
        ref_latch <= word_data; // [RULE_05] [RULE_11] [RULE_12]
      end
      if (load_fb) begin
        fb_latch <= word_data; // [RULE_05] [RULE_11]
      end
      if (load_func | load_init) begin
        function_latch <= word_data; // [RULE_06] [RULE_11]
      end
    end
  end

  assign lock_precision = ref_latch[R_PREC]; // [RULE_18]

  // ----------------------------------------------------------------
  // Internal reset pulse
  // ----------------------------------------------------------------
  logic init_pending;
  logic reset_pulse;

  always_ff @(posedge clk) begin
    if (reset) begin
      init_pending <= 1'b0;
    end else if (load_init) begin
      init_pending <= 1'b1;
    end else if (load_fb) begin
      init_pending <= 1'b0; // [RULE_09]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reset_pulse <= 1'b0;
    end else begin
      reset_pulse <= load_init | (load_fb & init_pending); // [RULE_09]
    end
  end

  // ----------------------------------------------------------------
  // Powerdown
  // ----------------------------------------------------------------
  logic sync_pd;
  logic pd_bits;
  logic next_pd_bits;

  assign pd_bits      = function_latch[F_PD_A] & function_latch[F_PD_B];
  assign next_pd_bits = word_data[F_PD_A] & word_data[F_PD_B];

  // Set wins over a clearing function load in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_pd <= 1'b0;
    end else if (reset_pulse & enable_sync & pd_bits) begin
      sync_pd <= 1'b1; // [RULE_08]
    end else if ((load_func | load_init) & ~next_pd_bits) begin
      sync_pd <= 1'b0;
    end
  end

  logic next_powerdown;
  logic held;

  assign next_powerdown = ~enable_sync | sync_pd; // [RULE_11]
  // Hold bit never feeds sync_pd
  assign held = reset_pulse | function_latch[F_HOLD] | powerdown; // [RULE_13]

  // ----------------------------------------------------------------
  // Speed-up request and timeout
  // ----------------------------------------------------------------
  logic       go;
  logic       timed_mode;
  logic [5:0] tmo_len;
  logic [5:0] tmo_count;
  logic       tmo_expire;

  assign timed_mode = function_latch[F_SPD_EN] & function_latch[F_SPD_TMO];
  assign tmo_len    = TMO_BASE
                    + {function_latch[F_TMO_HI:F_TMO_LO], 2'h0}; // [RULE_22]
  assign tmo_expire = timed_mode & go & reference_tick
                    & (tmo_count == 6'h01);

  // A new feedback load wins over an expiry in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      go <= 1'b0;
    end else if (load_fb) begin
      go <= word_data[N_GO]; // [RULE_15] [RULE_20]
    end else if (tmo_expire) begin
      go <= 1'b0; // [RULE_21]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tmo_count <= TMO_BASE;
    end else if (load_fb | reset_pulse) begin
      tmo_count <= tmo_len; // [RULE_07]
    end else if (timed_mode & go & reference_tick & (tmo_count != 6'h00)) begin
      tmo_count <= tmo_count - 6'h01; // [RULE_23]
    end
  end

  logic quarter;

  assign quarter = function_latch[F_SPD_EN] & function_latch[F_SPD_QTR] & go;

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  logic [13:0] ref_ratio;
  logic [13:0] ref_ratio_m1;
  logic [13:0] ref_count;

  assign ref_ratio    = quarter
                      ? (ref_latch[R_RATIO_HI:R_RATIO_LO] >> QTR_SHIFT)
                      : ref_latch[R_RATIO_HI:R_RATIO_LO]; // [RULE_25]
  assign ref_ratio_m1 = ref_ratio - 14'h0001;

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_count <= 14'h0000;
    end else if (held) begin
      ref_count <= ref_ratio_m1; // [RULE_07] [RULE_13]
    end else if (ref_count == 14'h0000) begin
      ref_count <= ref_ratio_m1;
    end else begin
      ref_count <= ref_count - 14'h0001;
    end
  end

  // One comparison cycle per reference period
  assign reference_tick = ~held & (ref_count == 14'h0000);

  // ----------------------------------------------------------------
  // Feedback divider: main and swallow counters
  // ----------------------------------------------------------------
  logic [12:0] main_load;
  logic [4:0]  swal_load;
  logic [12:0] main_count;
  logic [4:0]  swal_count;

  assign main_load = quarter
                   ? (fb_latch[N_MAIN_HI:N_MAIN_LO] >> QTR_SHIFT)
                   : fb_latch[N_MAIN_HI:N_MAIN_LO]; // [RULE_15] [RULE_25]
  assign swal_load = quarter
                   ? (fb_latch[N_SWAL_HI:N_SWAL_LO] >> QTR_SHIFT)
                   : fb_latch[N_SWAL_HI:N_SWAL_LO];

  always_ff @(posedge clk) begin
    if (reset) begin
      main_count <= 13'h0000;
      swal_count <= 5'h00;
    end else if (held) begin
      main_count <= main_load - 13'h0001; // [RULE_07] [RULE_13]
      swal_count <= swal_load;
    end else if (fb_edge) begin
      if (main_count == 13'h0000) begin
        main_count <= main_load - 13'h0001;
        swal_count <= swal_load;
      end else begin
        main_count <= main_count - 13'h0001;
        if (swal_count != 5'h00) begin
          swal_count <= swal_count - 5'h01;
        end
      end
    end
  end

  // Swallow pulses use modulus plus one, the rest plain modulus
  assign modulus_select = swal_count != 5'h00; // [RULE_16]
  assign feedback_tick  = ~held & fb_edge & (main_count == 13'h0000);

  // ----------------------------------------------------------------
  // Pump and speed-up output drive
  // ----------------------------------------------------------------
  pump_ctl_t  next_pump;
  pin_drive_t next_speedup;

  always_comb begin
    next_pump.hiz  = held; // [RULE_07] [RULE_13]
    next_pump.x4   = function_latch[F_SPD_EN] & go; // [RULE_20] [RULE_21]
    next_pump.high = ~function_latch[F_SPD_EN] & go; // [RULE_26]
    if (!function_latch[F_SPD_EN]) begin
      next_speedup.level = function_latch[F_SPD_QTR]; // [RULE_26]
      next_speedup.oe    = 1'b1;
    end else if (go) begin
      next_speedup.level = 1'b0;
      next_speedup.oe    = 1'b1;
    end else begin
      next_speedup.level = 1'b0;
      next_speedup.oe    = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pump_output     <= '{hiz: 1'b1, x4: 1'b0, high: 1'b0};
      speedup_output  <= '{level: 1'b0, oe: 1'b0};
      powerdown       <= 1'b1;
      divider_quarter <= 1'b0;
    end else begin
      pump_output     <= next_pump;
      speedup_output  <= next_speedup;
      powerdown       <= next_powerdown;
      divider_quarter <= quarter; // [RULE_24] [RULE_25]
    end
  end

endmodule : synth_serial_load_control
